/* pkg/osc_ctrl_cfg.svh */
// offsets, field positions, reset values and counts of the oscillator control
// assumes a 32-bit classic wishbone slave, one aligned word per register
`ifndef OSC_CTRL_CFG_SVH
`define OSC_CTRL_CFG_SVH

// ------------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------------
`define OSC_ADDR_CTRL     4'h0
`define OSC_ADDR_DIV      4'h4
`define OSC_ADDR_KEY      4'h8
`define OSC_ADDR_STAT     4'hC

// ------------------------------------------------------------------------
// oscillator control fields
// ------------------------------------------------------------------------
`define OSC_BIT_LOCK      7
`define OSC_BIT_PLLOK     5
`define OSC_BIT_FAIL      3
`define OSC_BIT_UNIMP     2
`define OSC_BIT_SECEN     1
`define OSC_BIT_SWREQ     0
`define OSC_NSEL_HI       10
`define OSC_NSEL_LO       8

// ------------------------------------------------------------------------
// clock divisor fields
// ------------------------------------------------------------------------
`define DIV_BIT_ROI       15
`define DIV_RED_HI        14
`define DIV_RED_LO        12
`define DIV_BIT_EN        11

// ------------------------------------------------------------------------
// reset values, key and counts
// ------------------------------------------------------------------------
`define OSC_CTRL_RST      16'h0000
`define OSC_DIV_RST       16'h3040
`define OSC_CTRL_WMASK    16'h0783
`define OSC_KEY1          16'h0046
`define OSC_KEY2          16'h0057
`define OSC_UNLOCK_WIN    8'h07
`define OSC_SW_CYCLES     8'h04

`endif

/* pkg/osc_ctrl_pkg.sv */
// types shared by the oscillator control block
// assumes the cfg header is included by the design files
package osc_ctrl_pkg;
  // unlock sequence states
  typedef enum logic [1:0] {
    UNL_IDLE = 2'b00,
    UNL_KEY1 = 2'b01,
    UNL_OPEN = 2'b10
  } unlock_state_t;
endpackage

/* hdl/reduction_divider.sv */
// processor clock reduction divider: emits a one-cycle peripheral tick
// assumes a single clock; ratio selects a power of two from 1 to 128
`timescale 1ns/1ps
module reduction_divider #(
  parameter int CW = 7
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic [2:0] ratio_i,
  output logic            tick_o
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] term;
  logic          wrap;

  // -----------------------------------------------------------------------
  // divide selection
  // -----------------------------------------------------------------------
  // ratio code map
  assign term  = CW'((8'h01 << ratio_i) - 8'h01);
  assign wrap  = !en_i || (cnt_q >= term);
  assign cnt_d = wrap ? '0 : cnt_q + CW'(1);

  // counter and tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_o <= wrap;
    end
  end
endmodule

/* hdl/osc_switch_ctrl.sv */
// oscillator control and clock divisor registers on classic wishbone
// assumes fail detect, pll lock and interrupt inputs arrive asynchronously
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "osc_ctrl_cfg.svh"
module osc_switch_ctrl #(
  parameter logic [7:0] SW_CYCLES = `OSC_SW_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        por_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        clk_fail_i,
  input  wire logic        pll_lock_i,
  input  wire logic        irq_i,
  output logic             sec_osc_en_o,
  output logic [2:0]       cur_source_o,
  output logic             periph_tick_o
);
  logic [15:0] ctrl_q;
  logic [15:0] div_q;
  logic [2:0]  cur_q;
  logic [7:0]  sw_cnt_q;
  logic [7:0]  win_q;
  logic [2:0]  fail_s, lock_s, irq_s;
  osc_ctrl_pkg::unlock_state_t unl_q;
  logic        acc, wr, rd_ctrl, rd_div, rd_stat, rd_key, lo_en;
  logic        fail_ev, irq_ev, sw_done, open, ctrl_wr, key_wr;
  logic [31:0] rdata;
  logic [15:0] ctrl_rd;

  // -----------------------------------------------------------------------
  // synchronisers
  // -----------------------------------------------------------------------
  // two flops before any use; third stage feeds edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_s <= 3'h0;
      lock_s <= 3'h0;
      irq_s  <= 3'h0;
    end else begin
      fail_s <= {fail_s[1:0], clk_fail_i};
      lock_s <= {lock_s[1:0], pll_lock_i};
      irq_s  <= {irq_s[1:0], irq_i};
    end
  end
  assign fail_ev = fail_s[1] & ~fail_s[2];
  assign irq_ev  = irq_s[1] & ~irq_s[2];

  // -----------------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------------
  assign acc     = cyc_i && stb_i && !ack_o;
  assign wr      = acc && we_i;
  assign lo_en   = sel_i[0] && sel_i[1];
  assign rd_ctrl = adr_i == `OSC_ADDR_CTRL;
  assign rd_div  = adr_i == `OSC_ADDR_DIV;
  assign rd_key  = adr_i == `OSC_ADDR_KEY;
  assign rd_stat = adr_i == `OSC_ADDR_STAT;
  assign key_wr  = wr && rd_key && lo_en;
  assign open    = unl_q == osc_ctrl_pkg::UNL_OPEN;
  assign ctrl_wr = wr && rd_ctrl && lo_en && open;

  always_comb begin
    ctrl_rd = ctrl_q;
    ctrl_rd[`OSC_BIT_UNIMP] = 1'b0;
    ctrl_rd[`OSC_BIT_PLLOK] = lock_s[1];
    ctrl_rd[14:12] = cur_q;
  end
  assign rdata = rd_ctrl ? {16'h0000, ctrl_rd} :
                 rd_div  ? {16'h0000, div_q} :
                 rd_stat ? {30'h0, open, ctrl_q[`OSC_BIT_SWREQ]} :
                 32'h0000_0000;

  // single-cycle ack, unmapped reads answer zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= acc;
      dat_o <= acc ? rdata : 32'h0000_0000;
    end
  end

  // -----------------------------------------------------------------------
  // unlock sequence
  // -----------------------------------------------------------------------
  // two keys, one write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unl_q <= osc_ctrl_pkg::UNL_IDLE;
      win_q <= 8'h00;
    end else begin
      case (unl_q)
        osc_ctrl_pkg::UNL_IDLE: begin
          if (key_wr && dat_i[15:0] == `OSC_KEY1) begin
            unl_q <= osc_ctrl_pkg::UNL_KEY1;
          end
        end
        osc_ctrl_pkg::UNL_KEY1: begin
          if (key_wr) begin
            unl_q <= (dat_i[15:0] == `OSC_KEY2) ? osc_ctrl_pkg::UNL_OPEN
                                                : osc_ctrl_pkg::UNL_IDLE;
            win_q <= `OSC_UNLOCK_WIN;
          end else if (wr) begin
            unl_q <= osc_ctrl_pkg::UNL_IDLE;
          end
        end
        osc_ctrl_pkg::UNL_OPEN: begin
          win_q <= win_q - 8'h01;
          if (wr || win_q == 8'h00) begin
            unl_q <= osc_ctrl_pkg::UNL_IDLE;
          end
        end
        default: unl_q <= osc_ctrl_pkg::UNL_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // switch sequencer
  // -----------------------------------------------------------------------
  // request held till done
  assign sw_done = ctrl_q[`OSC_BIT_SWREQ] && sw_cnt_q == 8'h00 &&
                   !ctrl_q[`OSC_BIT_LOCK];
  // switch counter and active source; runs only while unlocked
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      sw_cnt_q <= SW_CYCLES;
      cur_q    <= 3'h0;
    end else if (!ctrl_q[`OSC_BIT_SWREQ]) begin
      sw_cnt_q <= SW_CYCLES;
    end else if (!ctrl_q[`OSC_BIT_LOCK]) begin
      sw_cnt_q <= (sw_cnt_q == 8'h00) ? 8'h00 : sw_cnt_q - 8'h01;
      if (sw_done) begin
        cur_q <= ctrl_q[`OSC_NSEL_HI:`OSC_NSEL_LO];
      end
    end
  end

  // -----------------------------------------------------------------------
  // control and divisor registers, power-on reset only
  // -----------------------------------------------------------------------
  // only por resets
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      ctrl_q <= `OSC_CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= (ctrl_q & ~`OSC_CTRL_WMASK) | (dat_i[15:0] & `OSC_CTRL_WMASK);
        // fail flag: write 0 clears, 1 keeps
        ctrl_q[`OSC_BIT_FAIL] <= ctrl_q[`OSC_BIT_FAIL] & dat_i[`OSC_BIT_FAIL];
        // lock is sticky once set
        ctrl_q[`OSC_BIT_LOCK] <= ctrl_q[`OSC_BIT_LOCK] | dat_i[`OSC_BIT_LOCK];
        // a pending request cannot be withdrawn by software, only completed
        ctrl_q[`OSC_BIT_SWREQ] <= ctrl_q[`OSC_BIT_SWREQ] |
                                  dat_i[`OSC_BIT_SWREQ];
      end
      if (sw_done) begin
        ctrl_q[`OSC_BIT_SWREQ] <= 1'b0;
      end
      if (fail_ev) begin
        ctrl_q[`OSC_BIT_FAIL] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      div_q <= `OSC_DIV_RST;
    end else begin
      if (wr && rd_div) begin
        if (sel_i[0]) div_q[7:0] <= dat_i[7:0];
        if (sel_i[1]) div_q[15:8] <= dat_i[15:8];
      end
      if (irq_ev && div_q[`DIV_BIT_ROI]) begin
        div_q[`DIV_BIT_EN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      sec_osc_en_o <= 1'b0;
      cur_source_o <= 3'h0;
    end else begin
      sec_osc_en_o <= ctrl_q[`OSC_BIT_SECEN];
      cur_source_o <= cur_q;
    end
  end

  reduction_divider #(.CW(7)) u_div (
    .clk_i   (clk_i),
    .rst_i   (por_i),
    .en_i    (div_q[`DIV_BIT_EN]),
    .ratio_i (div_q[`DIV_RED_HI:`DIV_RED_LO]),
    .tick_o  (periph_tick_o)
  );

  // -----------------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------------
  AST_FAIL_SET: assert property (@(posedge clk_i) disable iff (por_i)
    fail_ev |=> ctrl_q[`OSC_BIT_FAIL]) else $error("fail flag not set");
  AST_UNIMP: assert property (@(posedge clk_i) disable iff (por_i)
    ack_o && $past(rd_ctrl) |-> !dat_o[2]) else $error("bit 2 not zero");
  AST_SECEN: assert property (@(posedge clk_i) disable iff (por_i)
    ##1 sec_osc_en_o == $past(ctrl_q[`OSC_BIT_SECEN]))
    else $error("secondary enable mismatch");
  AST_SW_HOLD: assert property (@(posedge clk_i) disable iff (por_i)
    $fell(ctrl_q[`OSC_BIT_SWREQ]) |-> $past(sw_done))
    else $error("request cleared early");
  AST_LOCKED_WR: assert property (@(posedge clk_i) disable iff (por_i)
    wr && rd_ctrl && !open |=> ctrl_q[1:0] == $past(ctrl_q[1:0]) ||
    $past(sw_done)) else $error("locked write took effect");
  AST_ROI: assert property (@(posedge clk_i) disable iff (por_i)
    irq_ev && div_q[`DIV_BIT_ROI] |=> !div_q[`DIV_BIT_EN])
    else $error("cpu_clock_reduction not cleared");
  AST_SWITCH_LOCK: assert property (@(posedge clk_i) disable iff (por_i)
    ctrl_q[`OSC_BIT_LOCK] |=> $stable(cur_q)) else $error("switch when locked");
  AST_PLLOK: assert property (@(posedge clk_i) disable iff (por_i)
    ack_o && $past(rd_ctrl) |-> dat_o[`OSC_BIT_PLLOK] == $past(lock_s[1]))
    else $error("pll lock mismatch");
  AST_ONEX: assert property (@(posedge clk_i) disable iff (por_i)
    !div_q[`DIV_BIT_EN] [*2] |-> periph_tick_o) else $error("not 1:1");
  AST_WIN: assert property (@(posedge clk_i) disable iff (por_i)
    open && wr |=> !open) else $error("window outlived write");
  CV_SWITCH: cover property (@(posedge clk_i) sw_done);
  CV_FAIL: cover property (@(posedge clk_i) fail_ev);
  CV_UNLOCK: cover property (@(posedge clk_i) ctrl_wr);
endmodule

/* verification/tb_top.sv */
// self-checking bench for the oscillator switch and reduction control
// assumes osc_switch_ctrl and its cfg header are on the include path
`timescale 1ns/1ps
`include "osc_ctrl_cfg.svh"
module tb_top;
  // ----------------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------------
  localparam int LIMIT = 20000; // whole run is about 1200 cycles
  logic        clk_i, rst_i, por_i, cyc_i, stb_i, we_i;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, seed;
  logic        ack_o, clk_fail_i, pll_lock_i, irq_i;
  logic        sec_osc_en_o, periph_tick_o;
  logic [2:0]  cur_source_o, nsel;
  logic [15:0] rd, dv;
  int          n_mismatch, checks_done, cycles, cnt;

  // a longer switch time keeps the pending bit visible to a read
  osc_switch_ctrl #(.SW_CYCLES(8'h10)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .clk_fail_i(clk_fail_i), .pll_lock_i(pll_lock_i), .irq_i(irq_i),
    .sec_osc_en_o(sec_osc_en_o), .cur_source_o(cur_source_o),
    .periph_tick_o(periph_tick_o));

  initial clk_i = 1'b0;
  always #20 clk_i = ~clk_i;

  // hang guard: counts as a mismatch and closes the run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      end_of_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ticks in a window: one per cycle when reduction is off
  function automatic int exp_ticks(input logic en, input int code,
                                   input int win);
    return en ? (win >> code) : win;
  endfunction

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // classic cycle: request held until the rising edge that samples ack high
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [15:0] d, output logic [15:0] r);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {16'h0000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 16) chk("ack", 16'h0001, 16'h0000);
    r = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdr(input logic [3:0] a);
    bus(1'b0, a, 16'h0000, rd);
  endtask

  task automatic uwr(input logic [15:0] d);
    wr(`OSC_ADDR_KEY, `OSC_KEY1);
    wr(`OSC_ADDR_KEY, `OSC_KEY2);
    wr(`OSC_ADDR_CTRL, d);
  endtask

  // f selects clock failure, else interrupt; held past the synchroniser
  task automatic evt(input logic f);
    if (f) clk_fail_i <= 1'b1;
    else irq_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    clk_fail_i <= 1'b0;
    irq_i <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask

  task automatic ticks(input int win);
    cnt = 0;
    repeat (win) begin
      @(negedge clk_i);
      cnt += int'(periph_tick_o === 1'b1);
    end
    @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'hE9861B9E;
    {n_mismatch, checks_done, cycles} = '0;
    {rst_i, por_i, sel_i} = 6'h3F;
    {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
    {clk_fail_i, pll_lock_i, irq_i} = 3'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    @(posedge clk_i);
    rdr(`OSC_ADDR_CTRL);
    chk("ctrl reset", `OSC_CTRL_RST, rd);
    rdr(`OSC_ADDR_DIV);
    chk("div reset", `OSC_DIV_RST, rd);
    wr(`OSC_ADDR_CTRL, 16'h0003);
    rdr(`OSC_ADDR_CTRL);
    chk("ctrl no unlock", 16'h0000, rd & `OSC_CTRL_WMASK);
    // start from plain fast rc, no pll-to-pll hop
    nsel = 3'(rnd()) | 3'h1;
    uwr({5'h00, nsel, 8'h07});
    rdr(`OSC_ADDR_CTRL);
    chk("ctrl low bits", 16'h0003, rd & 16'h0007);
    chk("sec osc", 16'h0001, {15'h0000, sec_osc_en_o});
    repeat (12) if (rd[0] === 1'b1) rdr(`OSC_ADDR_CTRL);
    chk("switch done", 16'h0000, {15'h0000, rd[0]});
    chk("source", {13'h0000, nsel}, {13'h0000, cur_source_o});
    pll_lock_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rdr(`OSC_ADDR_CTRL);
    chk("pll lock", 16'h0020, rd & 16'h0020);
    pll_lock_i <= 1'b0;
    evt(1'b1);
    rdr(`OSC_ADDR_CTRL);
    chk("fail set", 16'h0008, rd & 16'h0028);
    uwr({5'h00, nsel, 8'h02});
    rdr(`OSC_ADDR_CTRL);
    chk("fail clear", 16'h0000, rd & 16'h0008);
    for (int c = 3; c < 8; c++) begin
      dv = {1'b0, 3'(c), 1'b1, 11'h040};
      wr(`OSC_ADDR_DIV, dv);
      rdr(`OSC_ADDR_DIV);
      chk("ratio", dv & 16'hF800, rd & 16'hF800);
      ticks(4 << c);
      chk("ticks", 16'(exp_ticks(1'b1, c, 4 << c)), 16'(cnt));
    end
    wr(`OSC_ADDR_DIV, 16'h5040);
    ticks(16);
    chk("ticks off", 16'(exp_ticks(1'b0, 5, 16)), 16'(cnt));
    dv = 16'hC840;
    wr(`OSC_ADDR_DIV, dv);
    evt(1'b0);
    rdr(`OSC_ADDR_DIV);
    chk("roi clears", 16'hC000, rd & 16'hF800);
    dv = 16'h4840;
    wr(`OSC_ADDR_DIV, dv);
    evt(1'b0);
    rdr(`OSC_ADDR_DIV);
    chk("roi off", 16'h4800, rd & 16'hF800);
    uwr({5'h00, nsel, 8'h82});
    uwr({5'h00, nsel ^ 3'h2, 8'h83});
    repeat (30) @(posedge clk_i);
    chk("locked src", {13'h0, nsel}, {13'h0, cur_source_o});
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdr(`OSC_ADDR_DIV);
    chk("div kept", 16'h4800, rd & 16'hF800);
    rdr(`OSC_ADDR_CTRL);
    chk("ctrl kept", 16'h0082, rd & 16'h0082);
    por_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    por_i <= 1'b0;
    @(posedge clk_i);
    rdr(`OSC_ADDR_DIV);
    chk("div por", `OSC_DIV_RST, rd);
    rdr(`OSC_ADDR_CTRL);
    chk("ctrl por", `OSC_CTRL_RST, rd);
    end_of_test();
  end
endmodule
